// ---- hdl/dbf_pkg.sv ----
// constants and carrier types of the edge filter.
// assumes a 32-bit classic wishbone bus with byte addresses on bits 3:2.
package dbf_pkg;

  // ****
  // register map
  // ****
  localparam logic [1:0]  REG_CTRL      = 2'h0;
  localparam logic [1:0]  REG_GEOM      = 2'h1;
  localparam logic [1:0]  REG_OFFS      = 2'h2;
  localparam logic [1:0]  REG_STAT      = 2'h3;
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_AFF      = 1;
  localparam int          CTRL_FLD_PIC  = 2;
  localparam int          GEOM_W_LSB    = 0;
  localparam int          GEOM_H_LSB    = 8;
  localparam int          OFFS_A_LSB    = 0;
  localparam int          OFFS_B_LSB    = 8;
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_DONE     = 1;
  localparam int          STAT_X_LSB    = 8;
  localparam int          STAT_Y_LSB    = 16;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_0006;
  localparam logic [31:0] GEOM_MASK     = 32'h0000_FFFF;
  localparam logic [31:0] OFFS_MASK     = 32'h0000_3F3F;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [31:0] GEOM_RST      = 32'h0000_0101;
  localparam logic [31:0] OFFS_RST      = 32'h0000_0000;

  // ****
  // filter constants
  // ****
  localparam logic [5:0]         IDX_MAX       = 6'h33;
  localparam logic signed [12:0] MV_LIMIT      = 13'sh0004;
  localparam logic [3:0]         LUMA_LAST_LN  = 4'hF;
  localparam logic [3:0]         CHR_LAST_LN   = 4'h7;
  localparam logic [1:0]         LUMA_LAST_ED  = 2'h3;
  localparam logic [1:0]         CHR_LAST_ED   = 2'h1;
  localparam logic [1:0]         LAST_PLANE    = 2'h2;

  // entry i of each table sits at bits 8i+7..8i
  localparam logic [415:0] ALPHA_TAB = {
    96'hFFFFE2CBB6A2907F71655A50, 96'h473F38322D2824201C191614,
    96'h110F0D0C0A09080706050404, 128'h0};
  localparam logic [415:0] BETA_TAB = {
    96'h1212111110100F0F0E0E0D0D, 96'h0C0C0B0B0A0A090908080707,
    96'h060604040403030303020202, 128'h0};
  localparam logic [415:0] PIXEL_CLAMP_TAB = {
    96'h0D0B0A090807060605040404, 96'h030303020202020101010101,
    40'h0101010101, 184'h0};
  localparam logic [415:0] CLIP2_TAB = {
    96'h110F0D0C0B0A080807060505, 96'h040403030302020202010101,
    56'h01010101010101, 168'h0};
  localparam logic [415:0] RANGE_CLAMP_TAB = {
    96'h19171412100E0D0B0A090807, 96'h060605040404030303020202,
    88'h0201010101010101010101, 136'h0};

  // ****
  // types
  // ****
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_MBW   = 7'h02,
    S_FETCH = 7'h04,
    S_WAIT  = 7'h08,
    S_CALC  = 7'h10,
    S_WRITE = 7'h20,
    S_STEP  = 7'h40
  } dbf_state_t;

  typedef struct packed {
    logic               intra;
    logic               coded;
    logic [1:0]         ref_cnt;
    logic [3:0]         ref0;
    logic [3:0]         ref1;
    logic signed [11:0] mv0x;
    logic signed [11:0] mv0y;
    logic signed [11:0] mv1x;
    logic signed [11:0] mv1y;
    logic [5:0]         qp;
  } dbf_side_t;

  typedef struct packed {
    logic [7:0] mb_x;
    logic [7:0] mb_y;
    logic [1:0] plane;
    logic       dir;
    logic [1:0] edge_no;
    logic [3:0] line;
    logic       field;
  } dbf_addr_t;

  typedef struct packed {
    logic [7:0][7:0] smp;
    dbf_side_t       p;
    dbf_side_t       q;
  } dbf_line_t;

  typedef struct packed {
    dbf_addr_t       addr;
    logic [7:0][7:0] smp;
  } dbf_wr_t;

endpackage

// ---- hdl/dbf_edge_filter.sv ----
// deblocking edge filter: walks a picture macroblock by macroblock and
// filters one sample line across one edge at a time.
// assumes a frame store that returns a line (p3..q3, smp[0]=p3) with the
// side information of blocks p and q, and accepts the line back.
// Functional notes
// - visit all macroblocks in raster order
// - luma four vertical then four horizontal edges
// - chroma two edges of eight samples each
// - modify neighbours, never filter picture border edges
// - frame macroblock filters frame samples
// - field macroblock filters same parity samples
// - partner keeps unfiltered copy for intra prediction
// - field picture uses current field only
// - intra gives strength 3, boundary 4
// - coefficients give strength 2
// - reference or motion mismatch gives 1
// - filter line only under alpha beta tests
// - edges sequential on already updated samples
// - averaged quantiser is half the sum
// - lookup indices clamped to 0..51
// - fixed 52 entry alpha and beta tables
// - p0 q0 corrected by clipped delta
// - luma p1 q1 corrected when activity low
// - clip bound grows with low activity
// - base clip limit from index and strength
// - pixel clamp limits to 0..255
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
module dbf_edge_filter #(
  parameter int MBW = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              mb_avail_i,
  input  wire logic              mb_field_i,
  output logic                   mb_start_o,
  output logic                   fetch_valid_o,
  input  wire logic              fetch_ready_i,
  output dbf_pkg::dbf_addr_t     fetch_addr_o,
  input  wire logic              line_valid_i,
  input  wire dbf_pkg::dbf_line_t line_i,
  output logic                   store_valid_o,
  input  wire logic              store_ready_i,
  output dbf_pkg::dbf_wr_t       store_o,
  output logic                   pic_done_o
);

  if (MBW < 1 || MBW > 8) begin : g_chk
    $error("MBW must lie in 1..8");
  end

  // ****
  // functions
  // ****
  function automatic logic [7:0] absd(input logic [7:0] a,
    input logic [7:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  function automatic logic signed [11:0] sx(input logic [7:0] v);
    return $signed({4'h0, v});
  endfunction

  function automatic logic signed [11:0] range_clamp(
      input logic signed [11:0] x,
      input logic signed [11:0] lo,
      input logic signed [11:0] hi);
    if (x < lo) return lo;
    if (x > hi) return hi;
    return x;
  endfunction

  function automatic logic [7:0] pixel_clamp(input logic signed [11:0] x);
    if (x < 12'sh000) return 8'h00;
    if (x > 12'sh0FF) return 8'hFF;
    return x[7:0];
  endfunction

  function automatic logic [5:0] lut_index(input logic [5:0] q,
    input logic [5:0] o);
    logic signed [7:0] s;
    s = $signed({2'h0, q}) + $signed({{2{o[5]}}, o});
    if (s < 8'sh00) return 6'h00;
    if (s > $signed({2'h0, dbf_pkg::IDX_MAX})) return dbf_pkg::IDX_MAX;
    return s[5:0];
  endfunction

  function automatic logic mv_far(input logic signed [11:0] a,
    input logic signed [11:0] b);
    logic signed [12:0] d;
    d = $signed({a[11], a}) - $signed({b[11], b});
    return (d > dbf_pkg::MV_LIMIT) || (d < -dbf_pkg::MV_LIMIT);
  endfunction

  function automatic logic [2:0] strength(input dbf_pkg::dbf_side_t p,
    input dbf_pkg::dbf_side_t q,
    input logic mb_edge);
    logic two;
    two = (p.ref_cnt == 2'h2);
    if (p.intra || q.intra) return mb_edge ? 3'h4 : 3'h3;
    if (p.coded || q.coded) return 3'h2;
    if (p.ref_cnt != q.ref_cnt || p.ref0 != q.ref0 ||
        (two && p.ref1 != q.ref1)) return 3'h1;
    if (mv_far(p.mv0x, q.mv0x) || mv_far(p.mv0y, q.mv0y) ||
        (two && (mv_far(p.mv1x, q.mv1x) || mv_far(p.mv1y, q.mv1y))))
      return 3'h1;
    return 3'h0;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // ****
  // register bus
  // ****
  logic [31:0]         ctrl;
  logic [31:0]         geom;
  logic [31:0]         offs;
  logic                done;
  dbf_pkg::dbf_state_t st;
  dbf_pkg::dbf_state_t next_st;
  logic [MBW-1:0]      mb_x;
  logic [MBW-1:0]      mb_y;

  wire logic [1:0]  reg_sel  = wb_adr_i[3:2];
  wire logic        bus_req  = wb_cyc_i & wb_stb_i;
  wire logic        wr_stb   = bus_req & wb_ack_o & wb_we_i;
  wire logic        start    = wr_stb & (reg_sel == dbf_pkg::REG_CTRL) &
    wb_sel_i[0] & wb_dat_i[dbf_pkg::CTRL_START];
  wire logic        done_clr = wr_stb & (reg_sel == dbf_pkg::REG_STAT) &
    wb_sel_i[0] & wb_dat_i[dbf_pkg::STAT_DONE];
  wire logic        busy     = (st != dbf_pkg::S_IDLE);
  wire logic [31:0] stat_wd  = {8'h00, 8'(mb_y), 8'(mb_x), 6'h00,
    done, busy};
  wire logic [31:0] rd_word  =
    (reg_sel == dbf_pkg::REG_CTRL) ? ctrl :
    (reg_sel == dbf_pkg::REG_GEOM) ? geom :
    (reg_sel == dbf_pkg::REG_OFFS) ? offs : stat_wd;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= (bus_req & ~wb_ack_o & ~wb_we_i) ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= dbf_pkg::CTRL_RST;
      geom <= dbf_pkg::GEOM_RST;
      offs <= dbf_pkg::OFFS_RST;
    end else if (wr_stb) begin
      if (reg_sel == dbf_pkg::REG_CTRL)
        ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & dbf_pkg::CTRL_MASK;
      if (reg_sel == dbf_pkg::REG_GEOM)
        geom <= merge(geom, wb_dat_i, wb_sel_i) & dbf_pkg::GEOM_MASK;
      if (reg_sel == dbf_pkg::REG_OFFS)
        offs <= merge(offs, wb_dat_i, wb_sel_i) & dbf_pkg::OFFS_MASK;
    end
  end

  // ****
  // picture walk
  // ****
  logic [1:0] cur_plane;
  logic       cur_dir;
  logic [1:0] cur_edge;
  logic [3:0] cur_line;
  logic       fld;

  wire logic [7:0] pic_w      = geom[dbf_pkg::GEOM_W_LSB +: 8];
  wire logic [7:0] pic_h      = geom[dbf_pkg::GEOM_H_LSB +: 8];
  wire logic       luma       = (cur_plane == 2'h0);
  wire logic       last_line  = cur_line == (luma ? dbf_pkg::LUMA_LAST_LN :
    dbf_pkg::CHR_LAST_LN);
  wire logic       last_edge  = cur_edge == (luma ? dbf_pkg::LUMA_LAST_ED :
    dbf_pkg::CHR_LAST_ED);
  wire logic       last_plane = (cur_plane == dbf_pkg::LAST_PLANE);
  wire logic       last_col   = (8'(mb_x) == pic_w - 8'h01);
  wire logic       last_row   = (8'(mb_y) == pic_h - 8'h01);
  wire logic       mb_end     = last_line & last_edge & cur_dir & last_plane;
  wire logic       pic_end    = mb_end & last_col & last_row;
  wire logic       border     = (cur_edge == 2'h0) &
    (cur_dir ? (mb_y == '0) : (mb_x == '0));

  always_comb begin
    next_st = st;
    case (st)
      dbf_pkg::S_IDLE:  if (start) next_st = dbf_pkg::S_MBW;
      dbf_pkg::S_MBW:   if (mb_avail_i) next_st = dbf_pkg::S_FETCH;
      dbf_pkg::S_FETCH: begin
        if (border) next_st = dbf_pkg::S_STEP;
        else if (fetch_ready_i) next_st = dbf_pkg::S_WAIT;
      end
      dbf_pkg::S_WAIT:  if (line_valid_i) next_st = dbf_pkg::S_CALC;
      dbf_pkg::S_CALC:  next_st = dbf_pkg::S_WRITE;
      dbf_pkg::S_WRITE: if (store_ready_i) next_st = dbf_pkg::S_STEP;
      dbf_pkg::S_STEP: begin
        if (pic_end) next_st = dbf_pkg::S_IDLE;
        else if (mb_end) next_st = dbf_pkg::S_MBW;
        else next_st = dbf_pkg::S_FETCH;
      end
      default:          next_st = dbf_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) st <= dbf_pkg::S_IDLE;
    else st <= next_st;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (st == dbf_pkg::S_IDLE)) begin
      {mb_x, mb_y, cur_plane, cur_dir, cur_edge, cur_line} <= '0;
    end else if (st == dbf_pkg::S_STEP) begin
      cur_line <= last_line ? 4'h0 : cur_line + 4'h1;
      if (last_line) begin
        cur_edge <= last_edge ? 2'h0 : cur_edge + 2'h1;
        if (last_edge) begin
          cur_dir <= ~cur_dir;
          if (cur_dir) begin
            cur_plane <= last_plane ? 2'h0 : cur_plane + 2'h1;
            if (last_plane) begin
              mb_x <= last_col ? '0 : mb_x + MBW'(1);
              if (last_col) mb_y <= mb_y + MBW'(1);
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fld  <= 1'b0;
      done <= 1'b0;
    end else begin
      if (st == dbf_pkg::S_MBW && mb_avail_i)
        fld <= ctrl[dbf_pkg::CTRL_FLD_PIC] |
               (ctrl[dbf_pkg::CTRL_AFF] & mb_field_i);
      if (st == dbf_pkg::S_STEP && pic_end) done <= 1'b1;
      else if (done_clr) done <= 1'b0;
    end
  end

  // snapshot cue before the first edge
  assign mb_start_o    = (st == dbf_pkg::S_MBW) & mb_avail_i;
  assign fetch_valid_o = (st == dbf_pkg::S_FETCH) & ~border;
  assign store_valid_o = (st == dbf_pkg::S_WRITE);
  assign pic_done_o    = done;
  assign fetch_addr_o  = '{mb_x: 8'(mb_x), mb_y: 8'(mb_y),
    plane: cur_plane, dir: cur_dir,
    edge_no: cur_edge, line: cur_line,
    field: fld};

  // ****
  // line filter
  // ****
  dbf_pkg::dbf_line_t ln;
  logic [7:0][7:0]    filt;

  wire logic [7:0] p2 = ln.smp[1];
  wire logic [7:0] p1 = ln.smp[2];
  wire logic [7:0] p0 = ln.smp[3];
  wire logic [7:0] q0 = ln.smp[4];
  wire logic [7:0] q1 = ln.smp[5];
  wire logic [7:0] q2 = ln.smp[6];

  wire logic [2:0] bs     = strength(ln.p, ln.q, cur_edge == 2'h0);
  wire logic [6:0] qp_sum = {1'b0, ln.p.qp} + {1'b0, ln.q.qp};
  wire logic [5:0] avg_q  = qp_sum[6:1];
  wire logic [5:0] ia     = lut_index(avg_q, offs[dbf_pkg::OFFS_A_LSB +: 6]);
  wire logic [5:0] ib     = lut_index(avg_q, offs[dbf_pkg::OFFS_B_LSB +: 6]);
  wire logic [7:0] alpha  = dbf_pkg::ALPHA_TAB[{ia, 3'h0} +: 8];
  wire logic [7:0] beta   = dbf_pkg::BETA_TAB[{ib, 3'h0} +: 8];
  wire logic [7:0] c0     =
    (bs == 3'h1) ? dbf_pkg::PIXEL_CLAMP_TAB[{ia, 3'h0} +: 8] :
    (bs == 3'h2) ? dbf_pkg::CLIP2_TAB[{ia, 3'h0} +: 8] :
                   dbf_pkg::RANGE_CLAMP_TAB[{ia, 3'h0} +: 8];
  wire logic       ap_lt  = absd(p2, p0) < beta;
  wire logic       aq_lt  = absd(q2, q0) < beta;
  wire logic       do_flt = (bs != 3'h0) && (bs != 3'h4) &&
    (absd(p0, q0) < alpha) &&
    (absd(p1, p0) < beta) &&
    (absd(q1, q0) < beta);

  wire logic signed [11:0] c0s   = sx(c0);
  wire logic signed [11:0] c_lim = c0s + 12'(ap_lt) + 12'(aq_lt);
  wire logic signed [11:0] dsum  = ((sx(q0) - sx(p0)) <<< 2) +
    (sx(p1) - sx(q1)) + 12'sh004;
  wire logic signed [11:0] dlt   = range_clamp(dsum >>> 3, -c_lim,
    c_lim);
  wire logic signed [11:0] hpq   = (sx(p0) + sx(q0)) >>> 1;
  wire logic signed [11:0] tp    = (sx(p2) + hpq - (sx(p1) <<< 1)) >>> 1;
  wire logic signed [11:0] tq    = (sx(q2) + hpq - (sx(q1) <<< 1)) >>> 1;
  wire logic signed [11:0] cp    = range_clamp(tp, -c0s, c0s);
  wire logic signed [11:0] cq    = range_clamp(tq, -c0s, c0s);

  always_comb begin
    filt = ln.smp;
    if (do_flt) begin
      filt[3] = pixel_clamp(sx(p0) + dlt);
      filt[4] = pixel_clamp(sx(q0) - dlt);
      if (luma && ap_lt) filt[2] = pixel_clamp(sx(p1) + cp);
      if (luma && aq_lt) filt[5] = pixel_clamp(sx(q1) + cq);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ln      <= '0;
      store_o <= '0;
    end else begin
      if (st == dbf_pkg::S_WAIT && line_valid_i) ln <= line_i;
      if (st == dbf_pkg::S_CALC) begin
        store_o.addr <= fetch_addr_o;
        store_o.smp  <= filt;
      end
    end
  end

endmodule

// ---- tb/dbf_edge_filter_properties.sv ----
// checker bound into the edge filter.
// assumes one clock, sync active high reset.
`timescale 1ns/1ns
module dbf_edge_filter_properties #(
  parameter int MBW = 8
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic               mb_avail_i,
  input wire logic               mb_start_o,
  input wire logic               fetch_valid_o,
  input wire logic               fetch_ready_i,
  input wire dbf_pkg::dbf_addr_t fetch_addr_o,
  input wire logic               line_valid_i,
  input wire dbf_pkg::dbf_line_t line_i,
  input wire logic               store_valid_o,
  input wire logic               store_ready_i,
  input wire dbf_pkg::dbf_wr_t   store_o,
  input wire logic               pic_done_o
);
  // ****
  // helpers
  // ****
  logic       req_q;
  logic [7:0] cap_p3;
  logic [7:0] cap_q3;

  always_ff @(posedge clk_i) begin
    req_q <= wb_cyc_i && wb_stb_i && !wb_ack_o && !rst_i;
    if (line_valid_i) begin
      cap_p3 <= line_i.smp[0];
      cap_q3 <= line_i.smp[7];
    end
  end

  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_cause: assert property (wb_ack_o |-> req_q)
    else $error("stray ack");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("stray data");
  a_start_avail: assert property (mb_start_o |-> mb_avail_i)
    else $error("start unavailable");
  a_fetch_hold: assert property (fetch_valid_o && !fetch_ready_i |=>
    fetch_valid_o && $stable(fetch_addr_o))
    else $error("fetch unstable");
  a_store_hold: assert property (store_valid_o && !store_ready_i |=>
    store_valid_o && $stable(store_o))
    else $error("store unstable");
  a_one_inflight: assert property (fetch_valid_o && fetch_ready_i |=>
    !fetch_valid_o ##1 !store_valid_o)
    else $error("second line in flight");
  a_store_latency: assert property ($rose(store_valid_o) |->
    $past(line_valid_i, 2))
    else $error("store latency");
  a_ends_kept: assert property (store_valid_o |->
    store_o.smp[0] == cap_p3 && store_o.smp[7] == cap_q3)
    else $error("outer samples altered");
  a_done_quiet: assert property (pic_done_o |->
    !fetch_valid_o && !store_valid_o)
    else $error("late traffic");

  c_store: cover property (store_valid_o && store_ready_i);
  c_start: cover property (mb_start_o);
  c_done: cover property ($rose(pic_done_o));
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind dbf_edge_filter dbf_edge_filter_properties #(.MBW(MBW)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .mb_avail_i(mb_avail_i), .mb_start_o(mb_start_o),
  .fetch_valid_o(fetch_valid_o), .fetch_ready_i(fetch_ready_i),
  .fetch_addr_o(fetch_addr_o), .line_valid_i(line_valid_i), .line_i(line_i),
  .store_valid_o(store_valid_o), .store_ready_i(store_ready_i),
  .store_o(store_o), .pic_done_o(pic_done_o));

// ---- tb/dbf_store_model.sv ----
// frame store and reconstruction side: random lines, random stalls.
// assumes the fetch, line, store handshake of the edge filter.
`timescale 1ns/1ns
module dbf_store_model (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          fetch_valid_i,
  input  wire logic          mb_start_i,
  output logic               fetch_ready_o,
  output logic               store_ready_o,
  output logic               line_valid_o,
  output dbf_pkg::dbf_line_t line_o,
  output logic               mb_avail_o,
  output logic               mb_field_o,
  output int                 snapshots_o
);
  int                 seed = 32'h6d30;
  int                 wait_cnt;
  logic               pend;
  dbf_pkg::dbf_line_t held;

  // a released line bus shows the inverse
  assign line_o = line_valid_o ? held : ~held;

  function dbf_pkg::dbf_side_t new_side();
    new_side.intra   = ($random(seed) & 7) == 0;
    new_side.coded   = ($random(seed) & 3) == 0;
    new_side.ref_cnt = 2'h1 + 2'($random(seed) & 1);
    new_side.ref0    = 4'($random(seed) & 1);
    new_side.ref1    = 4'($random(seed) & 1);
    new_side.mv0x    = 12'($random(seed) % 4);
    new_side.mv0y    = 12'($random(seed) % 4);
    new_side.mv1x    = 12'($random(seed) % 4);
    new_side.mv1y    = 12'($random(seed) % 4);
    new_side.qp      = 6'(20 + ($random(seed) & 31));
  endfunction

  function dbf_pkg::dbf_line_t new_line();
    int base;
    base = $random(seed) & 255;
    for (int i = 0; i < 8; i++) new_line.smp[i] = 8'(base + $random(seed) % 5);
    new_line.p = new_side();
    new_line.q = new_side();
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      {fetch_ready_o, store_ready_o, line_valid_o} <= 3'h0;
      {pend, mb_avail_o, mb_field_o} <= 3'h0;
      snapshots_o <= 0;
    end else begin
      fetch_ready_o <= ($random(seed) & 3) != 0;
      store_ready_o <= ($random(seed) & 3) != 0;
      line_valid_o  <= 1'b0;
      mb_avail_o <= !mb_start_i && (mb_avail_o || ($random(seed) & 1));
      if (!mb_avail_o) mb_field_o <= 1'($random(seed));
      if (mb_start_i) snapshots_o <= snapshots_o + 1;
      if (fetch_valid_i && fetch_ready_o) begin
        pend     <= 1'b1;
        wait_cnt <= $random(seed) & 3;
      end else if (pend && wait_cnt == 0) begin
        pend         <= 1'b0;
        line_valid_o <= 1'b1;
        held         <= new_line();
      end else if (pend) wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// ---- tb/dbf_edge_filter_tb.sv ----
// self-checking bench: registers over wishbone, whole pictures filtered.
// assumes the store model in the far side position.
`timescale 1ns/1ns
module dbf_edge_filter_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mb_avail_i;
  logic mb_field_i, mb_start_o, fetch_valid_o, fetch_ready_i, line_valid_i;
  logic store_valid_o, store_ready_i, pic_done_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic fp, af, mf;
  dbf_pkg::dbf_addr_t fetch_addr_o, cur_a;
  dbf_pkg::dbf_line_t line_i, cur_l;
  dbf_pkg::dbf_wr_t store_o;
  logic signed [5:0] oa, ob;
  logic [63:0] exp_q[$];
  int seed, mismatches, total_checks, snaps, nstore, n_exp, w, h, n, sn;

  dbf_edge_filter #(.MBW(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mb_avail_i(mb_avail_i),
    .mb_field_i(mb_field_i), .mb_start_o(mb_start_o),
    .fetch_valid_o(fetch_valid_o), .fetch_ready_i(fetch_ready_i),
    .fetch_addr_o(fetch_addr_o), .line_valid_i(line_valid_i),
    .line_i(line_i), .store_valid_o(store_valid_o),
    .store_ready_i(store_ready_i), .store_o(store_o),
    .pic_done_o(pic_done_o));
  dbf_store_model u_store (.clk_i(clk_i), .rst_i(rst_i),
    .fetch_valid_i(fetch_valid_o), .mb_start_i(mb_start_o),
    .fetch_ready_o(fetch_ready_i), .store_ready_o(store_ready_i),
    .line_valid_o(line_valid_i), .line_o(line_i), .mb_avail_o(mb_avail_i),
    .mb_field_o(mb_field_i), .snapshots_o(snaps));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ****
  // checking and expectation
  // ****
  task test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] e,
                     input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  function automatic int clamp(int x, int lo, int hi);
    return x < lo ? lo : (x > hi ? hi : x);
  endfunction

  function automatic int absd(int a, int b);
    return a > b ? a - b : b - a;
  endfunction

  function automatic logic [63:0] exp_smp(dbf_pkg::dbf_line_t l,
                                          dbf_pkg::dbf_addr_t a);
    int s[8];
    int bs, qa, ia, ib, al, be, c0, c, d, ap, aq, hm;
    dbf_pkg::dbf_side_t p, r;
    logic [7:0][7:0] o;
    p = l.p;
    r = l.q;
    o = l.smp;
    for (int i = 0; i < 8; i++) s[i] = l.smp[i];
    if (p.intra || r.intra) bs = a.edge_no == 2'h0 ? 4 : 3;
    else if (p.coded || r.coded) bs = 2;
    else bs = int'(p.ref_cnt != r.ref_cnt || p.ref0 != r.ref0 ||
      absd(p.mv0x, r.mv0x) > 4 || absd(p.mv0y, r.mv0y) > 4 ||
      (p.ref_cnt == 2'h2 && (p.ref1 != r.ref1 ||
      absd(p.mv1x, r.mv1x) > 4 || absd(p.mv1y, r.mv1y) > 4)));
    qa = (int'(p.qp) + int'(r.qp)) >> 1;
    ia = clamp(qa + oa, 0, 51);
    ib = clamp(qa + ob, 0, 51);
    al = dbf_pkg::ALPHA_TAB[8*ia +: 8];
    be = dbf_pkg::BETA_TAB[8*ib +: 8];
    c0 = bs == 1 ? dbf_pkg::PIXEL_CLAMP_TAB[8*ia +: 8] : (bs == 2 ?
      dbf_pkg::CLIP2_TAB[8*ia +: 8] : dbf_pkg::RANGE_CLAMP_TAB[8*ia +: 8]);
    if (bs == 0 || bs == 4 || absd(s[3], s[4]) >= al ||
        absd(s[2], s[3]) >= be || absd(s[5], s[4]) >= be) return o;
    ap = int'(absd(s[1], s[3]) < be);
    aq = int'(absd(s[6], s[4]) < be);
    c = c0 + ap + aq;
    d = clamp(((s[4] - s[3]) * 4 + s[2] - s[5] + 4) >>> 3, -c, c);
    o[3] = 8'(clamp(s[3] + d, 0, 255));
    o[4] = 8'(clamp(s[4] - d, 0, 255));
    hm = (s[3] + s[4]) >>> 1;
    if (a.plane == 2'h0 && ap != 0) o[2] = 8'(clamp(s[2] + clamp((s[1] +
      hm - 2 * s[2]) >>> 1, -c0, c0), 0, 255));
    if (a.plane == 2'h0 && aq != 0) o[5] = 8'(clamp(s[5] + clamp((s[6] +
      hm - 2 * s[5]) >>> 1, -c0, c0), 0, 255));
    return o;
  endfunction

  always @(posedge clk_i) begin
    if (!rst_i && fetch_valid_o && fetch_ready_i) begin
      chk("fetch addr", exp_q.size() > 0 ? 64'({25'(exp_q.pop_front()),
          fp | af & mf}) : '1, 64'(fetch_addr_o));
      cur_a <= fetch_addr_o;
    end
    if (line_valid_i) cur_l <= line_i;
    if (mb_start_o) mf <= mb_field_i;
    if (!rst_i && store_valid_o && store_ready_i) begin
      chk("store addr", 64'(cur_a), 64'(store_o.addr));
      chk("samples", exp_smp(cur_l, cur_a), store_o.smp);
      nstore++;
    end
  end

  // ****
  // stimulus
  // ****
  task automatic wb_xfer(input logic we, input logic [3:0] adr,
                         input logic [31:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
      test_done();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  initial begin
    seed = 32'h6d30;
    {mismatches, total_checks, nstore, sn} = '0;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h0F, 32'h0};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, 4'h0, 32'h0);
    chk("ctrl reset", dbf_pkg::CTRL_RST, q);
    wb_xfer(1'b0, 4'h4, 32'h0);
    chk("geom reset", dbf_pkg::GEOM_RST, q);
    wb_xfer(1'b0, 4'h8, 32'h0);
    chk("offs reset", dbf_pkg::OFFS_RST, q);
    wb_xfer(1'b1, 4'h8, 32'hFFFF_FFFF);
    wb_xfer(1'b0, 4'h8, 32'h0);
    chk("offs mask", dbf_pkg::OFFS_MASK, q);
    for (int t = 0; t < 3; t++) begin
      w = t == 1 ? 3 : 2;
      h = t == 1 ? 1 : 2;
      fp = t == 1;
      af = t != 0;
      oa = t == 2 ? 6'h1F : 6'($random(seed));
      ob = t == 2 ? 6'h20 : 6'($random(seed));
      exp_q = {};
      for (int y = 0; y < h; y++) for (int x = 0; x < w; x++)
        for (int pl = 0; pl < 3; pl++) for (int dr = 0; dr < 2; dr++)
          for (int e = 0; e < (pl == 0 ? 4 : 2); e++)
            for (int l = 0; l < (pl == 0 ? 16 : 8); l++)
              if (e != 0 || (dr == 0 ? x : y) != 0) exp_q.push_back(
                64'({8'(x), 8'(y), 2'(pl), 1'(dr), 2'(e), 4'(l)}));
      n_exp = exp_q.size();
      nstore = 0;
      wb_xfer(1'b1, 4'h4, {16'h0, 8'(h), 8'(w)});
      wb_xfer(1'b1, 4'h8, {18'h0, ob, 2'h0, oa});
      wb_xfer(1'b1, 4'h0, {29'h0, fp, af, 1'b1});
      n = 0;
      while (pic_done_o !== 1'b1 && n < 40000) begin
        @(posedge clk_i);
        n++;
      end
      if (n >= 40000) begin
        mismatches++;
        test_done();
      end
      chk("store count", 64'(n_exp), 64'(nstore));
      sn += w * h;
      chk("snapshots", 64'(sn), 64'(snaps));
      wb_xfer(1'b0, 4'hC, 32'h0);
      chk("stat done", 64'h2, 64'(q & 32'h3));
      wb_xfer(1'b1, 4'hC, 32'h2);
      wb_xfer(1'b0, 4'hC, 32'h0);
      chk("stat clear", 64'h0, 64'(q & 32'h3));
    end
    test_done();
  end
endmodule
